// file: flash_regs_pkg.sv
/*
  Constants shared by the flash protection and command register block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package flash_regs_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_STATUS = 10'h106;
  localparam logic [9:0] IDX_COB_INDEX = 10'h102;
  localparam logic [9:0] IDX_DF_PROTECT = 10'h109;
  localparam logic [9:0] IDX_COB_HIGH = 10'h10a;
  localparam logic [9:0] IDX_COB_LOW = 10'h10b;
  localparam logic [9:0] IDX_TEST_RSV1 = 10'h10c;
  localparam logic [9:0] IDX_TEST_RSV2 = 10'h10d;
  localparam logic [9:0] IDX_TEST_RSV3 = 10'h10e;
  localparam logic [9:0] IDX_TEST_RSV4 = 10'h10f;
  localparam logic [9:0] IDX_OPTION = 10'h110;
  localparam logic [9:0] IDX_TEST_RSV5 = 10'h111;
  localparam int ADDR_LSB = 2;
  // Field positions.
  localparam int PROT_OPEN_BIT = 7;
  localparam int PROT_SIZE_MSB = 3;
  localparam int STAT_COMPLETE_BIT = 7;
  localparam int STAT_VIOL_BIT = 4;
  localparam int CMD_ADDR_HI_MSB = 1;
  // Fault fill values and the used bit mask of the protection register.
  localparam logic [7:0] PROT_FAULT_VALUE = 8'h0f;
  localparam logic [7:0] OPTION_FAULT_VALUE = 8'hff;
  localparam logic [7:0] PROT_USED_MASK = 8'h8f;
  // Command object layout.
  localparam int COB_WORDS = 6;
  localparam logic [2:0] COB_CMD_ADDR = 3'h0;
  localparam logic [2:0] COB_ADDR_LO = 3'h1;
  localparam logic [2:0] COB_DATA0 = 3'h2;
  // D-flash window and commands that alter it.
  localparam logic [17:0] DFLASH_BASE = 18'h04400;
  localparam logic [17:0] DFLASH_END = 18'h053ff;
  localparam int DF_STEP_SHIFT = 8;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_PROGRAM_DF = 8'h11;
  localparam logic [7:0] CMD_ERASE_DF_SECTOR = 8'h12;
endpackage : flash_regs_pkg

// file: flash_protect_command_regs.sv
/*
  APB register slice of an embedded flash controller: D-flash protection,
  indexed command object, command launch and completion, option byte and
  reserved test registers.
  Assumes the configuration bytes and their fault flags are stable at the
  release of presetn, and a command engine that answers with cmd_done.
*/
`timescale 1ns/1ps
module flash_protect_command_regs
  import flash_regs_pkg::*;
#(
  parameter int APB_AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] cfg_protect_byte,
  input wire logic cfg_protect_fault,
  input wire logic [7:0] cfg_option_byte,
  input wire logic cfg_option_fault,
  input wire logic cmd_done,
  input wire logic result_we,
  input wire logic [2:0] result_index,
  input wire logic [15:0] result_data,
  output logic cmd_start,
  output logic [7:0] command_code,
  output logic [17:0] cmd_address,
  output logic [63:0] cmd_data,
  output logic command_complete_flag
);
  import flash_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State.
  logic loaded_q;
  logic dflash_protect_open_q;
  logic [PROT_SIZE_MSB:0] dflash_protect_size_q;
  logic [7:0] option_bits_q;
  logic [2:0] command_object_index_q;
  logic [15:0] command_object_array [0:COB_WORDS-1];
  logic command_complete_flag_q;
  logic protect_violation_flag_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic cmd_start_q;
  logic [7:0] command_code_q;
  logic [17:0] cmd_address_q;
  logic [63:0] cmd_data_q;

  // True when the address lies in the protected D-flash range.
  function automatic logic df_protected(input logic open,
                                        input logic [3:0] size,
                                        input logic [17:0] addr);
    logic [17:0] top;
    top = DFLASH_BASE + ((18'(size) + 18'h1) << DF_STEP_SHIFT) - 18'h1;
    df_protected = !open && addr >= DFLASH_BASE && addr <= top;
  endfunction : df_protected

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.
  wire [9:0] reg_idx = paddr[ADDR_LSB +: 10];
  wire setup = psel && !penable && !pready_q;
  wire access = psel && penable && pready_q;
  wire wr_en = access && pwrite && !pslverr_q && pstrb[0];
  wire [7:0] wbyte = pwdata[7:0];
  wire idx_hit = (reg_idx == IDX_STATUS) || (reg_idx == IDX_COB_INDEX) ||
                 (reg_idx == IDX_DF_PROTECT) || (reg_idx == IDX_COB_HIGH) ||
                 (reg_idx == IDX_COB_LOW) || (reg_idx == IDX_TEST_RSV1) ||
                 (reg_idx == IDX_TEST_RSV2) || (reg_idx == IDX_TEST_RSV3) ||
                 (reg_idx == IDX_TEST_RSV4) || (reg_idx == IDX_OPTION) ||
                 (reg_idx == IDX_TEST_RSV5);
  wire aligned = (paddr[ADDR_LSB-1:0] == '0) &&
                 ((paddr >> (ADDR_LSB + 10)) == '0);
  wire addr_ok = idx_hit && aligned;

  wire wr_status = wr_en && reg_idx == IDX_STATUS;
  wire wr_prot = wr_en && reg_idx == IDX_DF_PROTECT;
  wire wr_index = wr_en && reg_idx == IDX_COB_INDEX &&
                  command_complete_flag_q;
  wire cob_valid = command_object_index_q < 3'(COB_WORDS);
  wire cob_wr_ok = command_complete_flag_q && cob_valid;
  wire wr_hi = wr_en && reg_idx == IDX_COB_HIGH && cob_wr_ok;
  wire wr_lo = wr_en && reg_idx == IDX_COB_LOW && cob_wr_ok;
  wire [15:0] cob_word = cob_valid ?
                         command_object_array[command_object_index_q] :
                         16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Protection register update: only stronger settings land.
  wire new_open = dflash_protect_open_q & wbyte[PROT_OPEN_BIT];
  wire size_up = wbyte[PROT_SIZE_MSB:0] > dflash_protect_size_q;
  wire [3:0] new_size = size_up ? wbyte[PROT_SIZE_MSB:0] :
                        dflash_protect_size_q;

  ////////////////////////////////////////////////////////////////////////
  // Launch and protection check.
  wire [7:0] obj_code = command_object_array[COB_CMD_ADDR][15:8];
  wire [17:0] obj_addr = {command_object_array[COB_CMD_ADDR]
                          [CMD_ADDR_HI_MSB:0],
                          command_object_array[COB_ADDR_LO]};
  wire launch_req = wr_status && wbyte[STAT_COMPLETE_BIT] &&
                    command_complete_flag_q;
  wire in_dflash = obj_addr >= DFLASH_BASE && obj_addr <= DFLASH_END;
  wire any_prot = !dflash_protect_open_q;
  wire alters = obj_code == CMD_PROGRAM_DF ||
                obj_code == CMD_ERASE_DF_SECTOR;
  wire hit_prot = alters && df_protected(dflash_protect_open_q,
                                         dflash_protect_size_q,
                                         obj_addr);
  wire block_prot = obj_code == CMD_ERASE_BLOCK && in_dflash &&
                    any_prot;
  wire violate = launch_req && (hit_prot || block_prot);
  wire launch = launch_req && !violate;
  wire viol_clr = wr_status && wbyte[STAT_VIOL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Read mux.
  logic [7:0] rbyte;
  always_comb begin
    case (reg_idx)
      IDX_STATUS: begin
        rbyte = 8'h00;
        rbyte[STAT_COMPLETE_BIT] = command_complete_flag_q;
        rbyte[STAT_VIOL_BIT] = protect_violation_flag_q;
      end
      IDX_COB_INDEX: rbyte = {5'h00, command_object_index_q};
      IDX_DF_PROTECT: rbyte = {dflash_protect_open_q, 3'h0,
                               dflash_protect_size_q};
      IDX_COB_HIGH: rbyte = cob_word[15:8];
      IDX_COB_LOW: rbyte = cob_word[7:0];
      IDX_OPTION: rbyte = option_bits_q;
      default: rbyte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: no wait state; pready is registered from the setup cycle, so every answer comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (pce) begin
      pready_q <= setup;
      pslverr_q <= setup && !addr_ok;
      if (setup) begin
        prdata_q <= (addr_ok && !pwrite) ? {24'h000000, rbyte} : 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration load on the first enabled edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      dflash_protect_open_q <= 1'b0;
      dflash_protect_size_q <= 4'hf;
      option_bits_q <= 8'hff;
    end else if (pce) begin
      if (!loaded_q) begin
        loaded_q <= 1'b1;
        if (cfg_protect_fault) begin
          dflash_protect_open_q <= PROT_FAULT_VALUE[PROT_OPEN_BIT];
          dflash_protect_size_q <= PROT_FAULT_VALUE[3:0];
        end else begin
          dflash_protect_open_q <= cfg_protect_byte[PROT_OPEN_BIT];
          dflash_protect_size_q <= cfg_protect_byte[3:0];
        end
        option_bits_q <= cfg_option_fault ? OPTION_FAULT_VALUE :
                         cfg_option_byte;
      end else if (wr_prot) begin
        dflash_protect_open_q <= new_open;
        dflash_protect_size_q <= new_size;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command object, completion flag and violation flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < COB_WORDS; i++) begin
        command_object_array[i] <= 16'h0000;
      end
      command_object_index_q <= 3'h0;
      command_complete_flag_q <= 1'b1;
      protect_violation_flag_q <= 1'b0;
    end else if (pce) begin
      if (wr_index) begin
        command_object_index_q <= wbyte[2:0];
      end
      if (wr_hi) begin
        command_object_array[command_object_index_q][15:8] <= wbyte;
      end
      if (wr_lo) begin
        command_object_array[command_object_index_q][7:0] <= wbyte;
      end
      if (!command_complete_flag_q && result_we &&
          result_index < 3'(COB_WORDS)) begin
        command_object_array[result_index] <= result_data;
      end
      if (launch) begin
        command_complete_flag_q <= 1'b0;
      end else if (!command_complete_flag_q && cmd_done) begin
        command_complete_flag_q <= 1'b1;
      end
      if (violate) begin
        protect_violation_flag_q <= 1'b1;
      end else if (viol_clr) begin
        protect_violation_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parameters handed to the command engine at launch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_start_q <= 1'b0;
      command_code_q <= 8'h00;
      cmd_address_q <= 18'h00000;
      cmd_data_q <= 64'h0;
    end else if (pce) begin
      cmd_start_q <= launch;
      if (launch) begin
        command_code_q <= obj_code;
        cmd_address_q <= obj_addr;
        cmd_data_q <= {command_object_array[COB_DATA0 + 3'h3],
                       command_object_array[COB_DATA0 + 3'h2],
                       command_object_array[COB_DATA0 + 3'h1],
                       command_object_array[COB_DATA0]};
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cmd_start = cmd_start_q;
  assign command_code = command_code_q;
  assign cmd_address = cmd_address_q;
  assign cmd_data = cmd_data_q;
  assign command_complete_flag = command_complete_flag_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_size_only_grows: assert property (
    loaded_q && pce |=> dflash_protect_size_q >=
      $past(dflash_protect_size_q))
    else $error("protection size decreased");
  a_open_never_sets: assert property (
    loaded_q && !dflash_protect_open_q |=> !dflash_protect_open_q)
    else $error("protection open bit went from 0 to 1");
  a_prot_fault_load: assert property (
    !loaded_q && pce && cfg_protect_fault |=>
      !dflash_protect_open_q && dflash_protect_size_q == 4'hf)
    else $error("faulted protection load not fully protected");
  a_opt_fault_load: assert property (
    !loaded_q && pce && cfg_option_fault |=> option_bits_q == 8'hff)
    else $error("faulted option load not all ones");
  a_opt_no_write: assert property (
    loaded_q |=> option_bits_q == $past(option_bits_q))
    else $error("option register changed after load");
  a_viol_sets_flag: assert property (
    pce && violate |=> protect_violation_flag_q && command_complete_flag_q &&
      !cmd_start_q)
    else $error("violation did not set flag or a command started");
  a_launch_clears_flag: assert property (
    pce && launch |=> !command_complete_flag_q && cmd_start_q ##1
      !cmd_start_q)
    else $error("launch did not clear complete flag with one start pulse");
  a_lock_while_busy: assert property (
    !command_complete_flag_q && !result_we |=>
      $stable(command_object_array[0]) && $stable(command_object_array[1]))
    else $error("command object changed while busy");
  a_done_sets_flag: assert property (
    pce && !command_complete_flag_q && cmd_done && !launch |=>
      command_complete_flag_q)
    else $error("completion did not set the flag");
  a_high_index_zero: assert property (
    setup && pce && !pwrite && command_object_index_q > 3'h5 &&
      (reg_idx == IDX_COB_HIGH || reg_idx == IDX_COB_LOW)
      |=> prdata_q == 32'h0)
    else $error("unimplemented object index read nonzero");
  a_rsv_reads_zero: assert property (
    setup && pce && !pwrite && (reg_idx == IDX_TEST_RSV1 ||
      reg_idx == IDX_TEST_RSV5) |=> prdata_q == 32'h0)
    else $error("reserved register read nonzero");
  a_block_erase_refused: assert property (
    pce && launch_req && obj_code == CMD_ERASE_BLOCK && in_dflash &&
      !dflash_protect_open_q |=> !cmd_start_q && protect_violation_flag_q)
    else $error("block erase launched while protected");
  a_protect_load: assert property (
    !loaded_q && pce && !cfg_protect_fault |=>
      dflash_protect_open_q == $past(cfg_protect_byte[PROT_OPEN_BIT]) &&
      dflash_protect_size_q == $past(cfg_protect_byte[PROT_SIZE_MSB:0]))
    else $error("protection register did not load the configuration");
  a_option_load: assert property (
    !loaded_q && pce && !cfg_option_fault |=>
      option_bits_q == $past(cfg_option_byte))
    else $error("option register did not load the configuration");
  a_weaken_ignored: assert property (
    loaded_q && pce && wr_prot &&
      wbyte[PROT_SIZE_MSB:0] <= dflash_protect_size_q |=>
      $stable(dflash_protect_size_q))
    else $error("protection size write without increase took effect");
  a_size_raise: assert property (
    loaded_q && pce && wr_prot &&
      wbyte[PROT_SIZE_MSB:0] > dflash_protect_size_q |=>
      dflash_protect_size_q == $past(wbyte[PROT_SIZE_MSB:0]))
    else $error("larger protection size write was not taken");
  a_base_protected: assert property (
    pce && launch_req && alters && !dflash_protect_open_q &&
      obj_addr == DFLASH_BASE |=> protect_violation_flag_q && !cmd_start_q)
    else $error("write at the protected range base was not refused");
  a_open_ignores_size: assert property (
    pce && launch_req && alters && dflash_protect_open_q |=> cmd_start_q)
    else $error("command refused while protection was open");
  a_index_locked: assert property (
    pce && !command_complete_flag_q |=> $stable(command_object_index_q))
    else $error("object index changed while busy");
  a_start_latches: assert property (
    pce && launch |=> command_code_q == $past(obj_code) &&
      cmd_address_q == $past(obj_addr))
    else $error("command code or address not latched at launch");
  a_start_when_busy: assert property (
    cmd_start_q |-> !command_complete_flag_q)
    else $error("start pulse while the complete flag is set");
  a_unused_bits_zero: assert property (
    setup && pce && !pwrite && reg_idx == IDX_DF_PROTECT |=>
      prdata_q[PROT_OPEN_BIT-1:PROT_SIZE_MSB+1] == '0)
    else $error("unused protection bits read nonzero");
  a_pready_one_cycle: assert property (
    pce && pready_q |=> !pready_q)
    else $error("pready held for more than one cycle");
  a_error_with_ready: assert property (
    pslverr_q |-> pready_q)
    else $error("pslverr raised outside the access cycle");
  a_unmapped_error: assert property (
    setup && pce && !addr_ok |=> pslverr_q && prdata_q == 32'h0)
    else $error("unmapped address did not answer with an error");
  a_enable_freezes: assert property (
    !pce |=> $stable(command_complete_flag_q) && $stable(pready_q) &&
      $stable(dflash_protect_size_q))
    else $error("state changed while the clock enable was low");
endmodule : flash_protect_command_regs

// file: testbench.sv
/*
  Self-checking testbench for the flash protection and command registers.
  Assumes flash_regs_pkg and flash_protect_command_regs are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import flash_regs_pkg::*;
  logic pclk, presetn, pce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] cfg_protect_byte, cfg_option_byte, command_code;
  logic cfg_protect_fault, cfg_option_fault, cmd_done, result_we;
  logic [2:0] result_index;
  logic [15:0] result_data;
  logic cmd_start, command_complete_flag;
  logic [17:0] cmd_address;
  logic [63:0] cmd_data;
  int miscompares = 0;
  int total_checks = 0;

  flash_protect_command_regs #(.APB_AW(12)) i_dut (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_protect_byte(cfg_protect_byte),
    .cfg_protect_fault(cfg_protect_fault),
    .cfg_option_byte(cfg_option_byte), .cfg_option_fault(cfg_option_fault),
    .cmd_done(cmd_done), .result_we(result_we),
    .result_index(result_index), .result_data(result_data),
    .cmd_start(cmd_start), .command_code(command_code),
    .cmd_address(cmd_address), .cmd_data(cmd_data),
    .command_complete_flag(command_complete_flag));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd,
                     output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    pstrb <= 4'h1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("mismatch pready expected 1 seen %b", pready);
      complete_run();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rdc(input string what, input logic [9:0] idx,
                     input logic [7:0] exp);
    logic [7:0] r;
    logic e;
    apb(1'b0, idx, 8'h00, r, e);
    chk(what, {56'h0, exp}, {56'h0, r});
  endtask : rdc

  task automatic do_reset(input logic [7:0] pb, input logic pf,
                          input logic [7:0] ob, input logic of);
    @(posedge pclk);
    cfg_protect_byte <= pb;
    cfg_protect_fault <= pf;
    cfg_option_byte <= ob;
    cfg_option_fault <= of;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  // Loads code and address words, then writes 1 to the complete flag.
  task automatic launch(input logic [7:0] code, input logic [17:0] addr,
                        input logic ok);
    wr(IDX_COB_INDEX, 8'h00);
    wr(IDX_COB_HIGH, code);
    wr(IDX_COB_LOW, {6'h00, addr[17:16]});
    wr(IDX_COB_INDEX, 8'h01);
    wr(IDX_COB_HIGH, addr[15:8]);
    wr(IDX_COB_LOW, addr[7:0]);
    wr(IDX_STATUS, 8'h80);
    #1;
    chk("cmd_start", {63'h0, ok}, {63'h0, cmd_start});
    chk("flag", {63'h0, !ok}, {63'h0, command_complete_flag});
    if (!ok) begin
      rdc("status viol", IDX_STATUS, 8'h90);
      wr(IDX_STATUS, 8'h10);
      rdc("status clr", IDX_STATUS, 8'h80);
    end
  endtask : launch

  task automatic finish_cmd();
    int n;
    @(posedge pclk);
    result_we <= 1'b1;
    result_index <= 3'h2;
    result_data <= 16'hbeef;
    @(posedge pclk);
    result_we <= 1'b0;
    cmd_done <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (command_complete_flag !== 1'b1 && n < 8);
    cmd_done <= 1'b0;
    chk("flag done", 64'h1, {63'h0, command_complete_flag});
    if (command_complete_flag !== 1'b1) complete_run();
  endtask : finish_cmd

  //////////////////////////////////////////////////////////////////////////
  task automatic test_command();
    logic [63:0] exp_data;
    for (int i = 2; i < 6; i++) begin
      wr(IDX_COB_INDEX, 8'(i));
      wr(IDX_COB_HIGH, 8'(i * 17 + 3));
      wr(IDX_COB_LOW, 8'(i * 5));
      exp_data[(i - 2) * 16 +: 16] = {8'(i * 17 + 3), 8'(i * 5)};
    end
    for (int i = 2; i < 8; i++) begin
      wr(IDX_COB_INDEX, 8'(i));
      if (i > 5) wr(IDX_COB_HIGH, 8'hff);
      if (i > 5) wr(IDX_COB_LOW, 8'hff);
      rdc("obj high", IDX_COB_HIGH, (i > 5) ? 8'h00 : 8'(i * 17 + 3));
      rdc("obj low", IDX_COB_LOW, (i > 5) ? 8'h00 : 8'(i * 5));
    end
    launch(8'h11, 18'h04400, 1'b1);
    chk("code", 64'h11, {56'h0, command_code});
    chk("address", 64'h04400, {46'h0, cmd_address});
    chk("data", exp_data, cmd_data);
    @(posedge pclk);
    #1;
    chk("start pulse", 64'h0, {63'h0, cmd_start});
    wr(IDX_COB_HIGH, 8'h55);
    rdc("status busy", IDX_STATUS, 8'h00);
    finish_cmd();
    rdc("obj locked", IDX_COB_HIGH, 8'h44);
    wr(IDX_COB_INDEX, 8'h02);
    rdc("result high", IDX_COB_HIGH, 8'hbe);
    rdc("result low", IDX_COB_LOW, 8'hef);
    $display("test command done");
  endtask : test_command

  task automatic test_protect();
    wr(IDX_DF_PROTECT, 8'h83);
    rdc("size lower", IDX_DF_PROTECT, 8'h85);
    wr(IDX_DF_PROTECT, 8'h85);
    rdc("size equal", IDX_DF_PROTECT, 8'h85);
    wr(IDX_DF_PROTECT, 8'hf7);
    rdc("size higher", IDX_DF_PROTECT, 8'h87);
    wr(IDX_DF_PROTECT, 8'h07);
    rdc("open clear", IDX_DF_PROTECT, 8'h07);
    wr(IDX_DF_PROTECT, 8'h88);
    rdc("open set", IDX_DF_PROTECT, 8'h08);
    wr(IDX_DF_PROTECT, 8'h02);
    rdc("weaken", IDX_DF_PROTECT, 8'h08);
    $display("test protect done");
  endtask : test_protect

  task automatic test_violation();
    launch(8'h11, 18'h04cff, 1'b0);
    launch(8'h12, 18'h04d00, 1'b1);
    finish_cmd();
    launch(8'h12, 18'h04400, 1'b0);
    launch(8'h09, 18'h053ff, 1'b0);
    $display("test violation done");
  endtask : test_violation

  task automatic test_reserved();
    logic [9:0] idx [6];
    logic [7:0] r;
    logic e;
    idx = '{IDX_TEST_RSV1, IDX_TEST_RSV2, IDX_TEST_RSV3, IDX_TEST_RSV4,
            IDX_TEST_RSV5, IDX_OPTION};
    foreach (idx[i]) begin
      wr(idx[i], 8'hff);
      rdc("reserved", idx[i], (i == 5) ? 8'h5a : 8'h00);
    end
    apb(1'b0, 10'h3ff, 8'h00, r, e);
    chk("unmapped err", 64'h1, {63'h0, e});
    $display("test reserved done");
  endtask : test_reserved

  task automatic test_reset();
    do_reset(8'hf5, 1'b0, 8'h5a, 1'b0);
    rdc("protect load", IDX_DF_PROTECT, 8'h85);
    rdc("option load", IDX_OPTION, 8'h5a);
    rdc("status idle", IDX_STATUS, 8'h80);
    $display("test reset done");
  endtask : test_reset

  // Setup held with the enable low must not be answered until it rises.
  task automatic test_clock_enable();
    int n;
    @(posedge pclk);
    pce <= 1'b0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= 1'b1;
    paddr <= {IDX_DF_PROTECT, 2'b00};
    pwdata <= 32'h0000_000f;
    pstrb <= 4'h1;
    repeat (3) @(posedge pclk);
    #1;
    chk("frozen pready", 64'h0, {63'h0, pready});
    @(posedge pclk);
    pce <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    chk("enable pready", 64'h1, {63'h0, pready});
    if (pready !== 1'b1) complete_run();
    rdc("enable write", IDX_DF_PROTECT, 8'h0f);
    $display("test clock enable done");
  endtask : test_clock_enable

  task automatic test_fault();
    do_reset(8'h80, 1'b1, 8'h00, 1'b1);
    rdc("protect fault", IDX_DF_PROTECT, PROT_FAULT_VALUE);
    rdc("option fault", IDX_OPTION, OPTION_FAULT_VALUE);
    launch(8'h11, 18'h053ff, 1'b0);
    $display("test fault done");
  endtask : test_fault

  initial begin
    presetn = 1'b0;
    pce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    cfg_protect_byte = 8'h00;
    cfg_protect_fault = 1'b0;
    cfg_option_byte = 8'h00;
    cfg_option_fault = 1'b0;
    cmd_done = 1'b0;
    result_we = 1'b0;
    result_index = 3'h0;
    result_data = 16'h0000;
    test_reset();
    test_command();
    test_protect();
    test_violation();
    test_reserved();
    test_clock_enable();
    test_fault();
    complete_run();
  end
endmodule : testbench
